// ### hw/pixel_merge.sv
// Per-pixel combination of the two sensor rows for the selected mode
`timescale 1ns/1ps
`default_nettype none

module pixel_merge (
   input wire tdi_pkg::tdi_mode_e mode_i,             // Active mode
   input wire logic [tdi_pkg::PIX_W-1:0] row1_pix_i,  // Row one pixel
   input wire logic [tdi_pkg::PIX_W-1:0] row2_pix_i,  // Row two pixel
   output logic [tdi_pkg::PIX_W-1:0] merged_o         // Combined pixel
);

   // ***************************************************************
   // Mode select
   // ***************************************************************
   // Purely combinational; the caller registers the result
   always_comb begin
      case (mode_i)
         tdi_pkg::MODE_HISENS: begin
            merged_o = tdi_pkg::sum_clamp(row1_pix_i, row2_pix_i);
         end
         tdi_pkg::MODE_SNR: begin
            merged_o = tdi_pkg::avg2(row1_pix_i, row2_pix_i);
         end
         tdi_pkg::MODE_HDR: begin
            merged_o = tdi_pkg::hdr_merge(row1_pix_i, row2_pix_i);
         end
         default: begin
            // Single and multi-row pass row one straight through
            merged_o = row1_pix_i;
         end
      endcase
   end

endmodule // pixel_merge

`default_nettype wire

// ### hw/tdi_pkg.sv
// Shared constants, types and pixel arithmetic of the two-row line combiner
package tdi_pkg;

   // ***************************************************************
   // Widths and sizes
   // ***************************************************************
   localparam int PIX_W = 12;         // Sensor and output pixel width
   localparam int LINE_PIXELS = 4096; // Pixels in one sensor row
   localparam int ADDR_W = 12;        // Row buffer address width
   localparam int PER_W = 24;         // Line period counter width
   localparam int TDI_STAGES = 2;     // Integration stages of the sensor

   // ***************************************************************
   // Pixel and period constants
   // ***************************************************************
   localparam logic [PIX_W-1:0] PIX_MAX = 12'hfff;  // Clamp value
   localparam logic [PIX_W-1:0] HDR_KNEE = 12'hf00; // Long row counts as saturated
   localparam int HDR_SHIFT = 2;                    // Long to short exposure ratio, log2
   localparam logic [PER_W-1:0] PER_MAX = 24'hffffff; // Period saturation
   localparam logic [PER_W-1:0] PER_ONE = 24'h000001; // Period restart value

   // ***************************************************************
   // Modes and states
   // ***************************************************************
   typedef enum logic [2:0] {
      MODE_SINGLE = 3'b000,  // One row per trigger
      MODE_HISENS = 3'b001,  // Sum of both rows
      MODE_SNR    = 3'b010,  // Average of both rows
      MODE_HDR    = 3'b011,  // Short and long exposure merged
      MODE_MULTI  = 3'b100   // Both rows in turn
   } tdi_mode_e;

   localparam tdi_mode_e MODE_RESET = MODE_SINGLE; // Mode after reset

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,  // Waiting for a trigger
      ST_STREAM = 2'b01,  // Sensor rows arriving
      ST_REPLAY = 2'b10   // Second row leaving from buffer
   } line_state_e;

   // ***************************************************************
   // Arithmetic
   // ***************************************************************
   // Sum that saturates instead of wrapping
   function automatic logic [PIX_W-1:0] sum_clamp(input logic [PIX_W-1:0] a,
                                                  input logic [PIX_W-1:0] b);
      logic [PIX_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[PIX_W] ? PIX_MAX : s[PIX_W-1:0];
   endfunction

   // Average, truncating the half bit
   function automatic logic [PIX_W-1:0] avg2(input logic [PIX_W-1:0] a,
                                             input logic [PIX_W-1:0] b);
      logic [PIX_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[PIX_W:1];
   endfunction

   // Long row unless saturated, then the scaled short row
   function automatic logic [PIX_W-1:0] hdr_merge(input logic [PIX_W-1:0] lng,
                                                  input logic [PIX_W-1:0] sht);
      logic [PIX_W+1:0] sc;
      sc = (PIX_W+2)'(sht) << HDR_SHIFT;
      if (lng < HDR_KNEE) begin
         return lng;
      end
      return (sc > (PIX_W+2)'(PIX_MAX)) ? PIX_MAX : sc[PIX_W-1:0];
   endfunction

   // Line period times the stage count, saturating
   function automatic logic [PER_W-1:0] stage_scale(input logic [PER_W-1:0] p);
      logic [PER_W+1:0] s;
      s = (PER_W+2)'(p) * (PER_W+2)'(TDI_STAGES);
      return (s > (PER_W+2)'(PER_MAX)) ? PER_MAX : s[PER_W-1:0];
   endfunction

endpackage

// ### hw/tdi_row_combiner.sv
// Line trigger handling, row combining and output streaming of the two-row sensor
//
// Overview of operation
// - Five imaging modes are selectable
// - Reset selects single row, one row per trigger
// - High sensitivity sums both rows per pixel
// - Enhanced noise mode averages both rows
// - Dynamic range mode merges short and long rows
// - Multi-row emits row one, then row two
`timescale 1ns/1ps
`default_nettype none

module tdi_row_combiner (
   input wire logic ref_clk_i,                            // Pixel clock, 250 MHz
   input wire logic rst_i,                                // Asynchronous reset, high
   input wire logic external_line_trigger_i,              // Line trigger pin
   input wire logic mode_load_i,                          // Load mode_sel_i
   input wire logic [2:0] mode_sel_i,                     // Requested mode code
   input wire logic sens_valid_i,                         // Sensor pixel pair valid
   input wire logic sens_last_i,                          // Last pixel of the rows
   input wire logic [tdi_pkg::PIX_W-1:0] row1_pix_i,      // Row one pixel
   input wire logic [tdi_pkg::PIX_W-1:0] row2_pix_i,      // Row two pixel
   output logic line_req_o,                               // Start exposure and readout
   output logic hdr_split_o,                              // Expose row two short
   output logic [2:0] mode_o,                             // Active mode
   output logic [tdi_pkg::PIX_W-1:0] pix_o,               // Output pixel
   output logic pix_valid_o,                              // Output pixel valid
   output logic pix_last_o,                               // Last pixel of a row
   output logic row_two_o,                                // Pixel comes from row two
   output logic trig_overrun_o,                           // Trigger dropped while busy
   output logic [tdi_pkg::PER_W-1:0] integ_cycles_o       // Effective integration, cycles
);

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      tdi_pkg::line_state_e st;               // Line sequencer
      tdi_pkg::tdi_mode_e mode;               // Active mode
      logic trig_m;                           // Synchroniser, first stage
      logic trig_s;                           // Synchroniser, second stage
      logic trig_p;                           // Previous synchronised level
      logic req;                              // Readout request pulse
      logic overrun;                          // Dropped trigger pulse
      logic [tdi_pkg::ADDR_W-1:0] wr_addr;    // Row two write pointer
      logic [tdi_pkg::ADDR_W-1:0] last_addr;  // Last stored pixel
      logic [tdi_pkg::ADDR_W-1:0] rd_addr;    // Replay pointer
      logic [tdi_pkg::PIX_W-1:0] pix;         // Output pixel
      logic vld;                              // Output valid
      logic last;                             // Output end of row
      logic row2;                             // Output row tag
      logic hdr;                              // Split exposure level
      logic [tdi_pkg::PER_W-1:0] period;      // Cycles since last trigger
      logic [tdi_pkg::PER_W-1:0] integ;       // Effective integration time
   } comb_s;

   comb_s q;  // Registered state
   comb_s d;  // Next state

   // Row two buffer for multi-row replay
   logic [tdi_pkg::PIX_W-1:0] row_mem [tdi_pkg::LINE_PIXELS];
   logic [tdi_pkg::PIX_W-1:0] mem_rd;   // Buffer read data
   logic [tdi_pkg::PIX_W-1:0] merged;   // Combined pixel
   logic trig_edge;                     // Rising trigger edge
   logic combined;                      // Mode that uses both rows for one line

   // ***************************************************************
   // Row combination
   // ***************************************************************
   pixel_merge u_merge (
      .mode_i(q.mode),
      .row1_pix_i(row1_pix_i),
      .row2_pix_i(row2_pix_i),
      .merged_o(merged)
   );

   // ***************************************************************
   // Row buffer
   // ***************************************************************
   // No reset on the array; it is always written before it is read
   always_ff @(posedge ref_clk_i) begin
      if (q.st == tdi_pkg::ST_STREAM && sens_valid_i && q.mode == tdi_pkg::MODE_MULTI) begin
         row_mem[q.wr_addr] <= row2_pix_i;
      end
   end

   assign mem_rd = row_mem[q.rd_addr];

   // ***************************************************************
   // Next state
   // ***************************************************************
   // Trigger edge uses only the second and third stages
   assign trig_edge = q.trig_s & ~q.trig_p;
   assign combined = (q.mode == tdi_pkg::MODE_HISENS) || (q.mode == tdi_pkg::MODE_SNR) ||
                     (q.mode == tdi_pkg::MODE_HDR);

   always_comb begin
      d = q;
      d.req = 1'b0;
      d.overrun = 1'b0;
      d.vld = 1'b0;
      d.last = 1'b0;
      // Pin passes two flops before anything looks at it
      d.trig_m = external_line_trigger_i;
      d.trig_s = q.trig_m;
      d.trig_p = q.trig_s;
      // Mode changes only between lines, so a row is never split across modes
      if (mode_load_i && q.st == tdi_pkg::ST_IDLE && mode_sel_i <= 3'h4) begin
         d.mode = tdi_pkg::tdi_mode_e'(mode_sel_i);
      end
      d.hdr = (q.mode == tdi_pkg::MODE_HDR);
      // Line period measured between triggers
      if (trig_edge) begin
         d.period = tdi_pkg::PER_ONE;
         d.integ = combined ? tdi_pkg::stage_scale(q.period) : q.period;
      end else if (q.period != tdi_pkg::PER_MAX) begin
         d.period = q.period + tdi_pkg::PER_ONE;
      end
      case (q.st)
         tdi_pkg::ST_IDLE: begin
            if (trig_edge) begin
               // One readout per trigger
               d.req = 1'b1;
               d.st = tdi_pkg::ST_STREAM;
               d.wr_addr = '0;
            end
         end
         tdi_pkg::ST_STREAM: begin
            // A trigger mid-line is dropped and flagged
            d.overrun = trig_edge;
            if (sens_valid_i) begin
               d.pix = merged;
               d.vld = 1'b1;
               d.row2 = 1'b0;
               d.last = sens_last_i;
               d.wr_addr = q.wr_addr + 1'b1;
               if (sens_last_i) begin
                  if (q.mode == tdi_pkg::MODE_MULTI) begin
                     // Row one went out live, row two follows
                     d.st = tdi_pkg::ST_REPLAY;
                     d.last_addr = q.wr_addr;
                     d.rd_addr = '0;
                  end else begin
                     d.st = tdi_pkg::ST_IDLE;
                  end
               end
            end
         end
         tdi_pkg::ST_REPLAY: begin
            d.overrun = trig_edge;
            d.pix = mem_rd;
            d.vld = 1'b1;
            d.row2 = 1'b1;
            d.rd_addr = q.rd_addr + 1'b1;
            if (q.rd_addr == q.last_addr) begin
               d.last = 1'b1;
               d.st = tdi_pkg::ST_IDLE;
            end
         end
         default: begin
            d.st = tdi_pkg::ST_IDLE;
         end
      endcase
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
         q.st <= tdi_pkg::ST_IDLE;
         q.mode <= tdi_pkg::MODE_RESET;
      end else begin
         q <= d;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign line_req_o = q.req;
   assign hdr_split_o = q.hdr;
   assign mode_o = q.mode;
   assign pix_o = q.pix;
   assign pix_valid_o = q.vld;
   assign pix_last_o = q.last;
   assign row_two_o = q.row2;
   assign trig_overrun_o = q.overrun;
   assign integ_cycles_o = q.integ;

   // ***************************************************************
   // Checks
   // ***************************************************************
   a_mode_legal: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (q.mode <= tdi_pkg::MODE_MULTI) && (!mode_load_i || q.st != tdi_pkg::ST_IDLE)
      |=> (q.mode == $past(q.mode)))
      else $error("mode changed without a load");

   a_single_line: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (q.st == tdi_pkg::ST_STREAM && sens_valid_i && sens_last_i &&
       q.mode == tdi_pkg::MODE_SINGLE)
      |=> (pix_last_o && !row_two_o && q.st == tdi_pkg::ST_IDLE))
      else $error("single row mode emitted more than one row");

   a_sum_rows: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (q.st == tdi_pkg::ST_STREAM && sens_valid_i && q.mode == tdi_pkg::MODE_HISENS)
      |=> (pix_valid_o && pix_o == tdi_pkg::sum_clamp($past(row1_pix_i), $past(row2_pix_i))))
      else $error("summed pixel wrong");

   a_avg_rows: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (q.st == tdi_pkg::ST_STREAM && sens_valid_i && q.mode == tdi_pkg::MODE_SNR)
      |=> (pix_valid_o && pix_o == tdi_pkg::avg2($past(row1_pix_i), $past(row2_pix_i))))
      else $error("averaged pixel wrong");

   a_integ_time: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (trig_edge && q.mode == tdi_pkg::MODE_HISENS)
      |=> (integ_cycles_o == tdi_pkg::stage_scale($past(q.period))))
      else $error("integration time not twice the line period");

   a_trig_request: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (trig_edge && q.st == tdi_pkg::ST_IDLE) |=> line_req_o ##1 !line_req_o)
      else $error("trigger did not give one request pulse");

   a_hdr_long: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (q.st == tdi_pkg::ST_STREAM && sens_valid_i && q.mode == tdi_pkg::MODE_HDR &&
       row1_pix_i < tdi_pkg::HDR_KNEE)
      |=> (pix_o == $past(row1_pix_i) && hdr_split_o))
      else $error("unsaturated long exposure not passed");

   a_multi_order: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (q.st == tdi_pkg::ST_STREAM && sens_valid_i && sens_last_i &&
       q.mode == tdi_pkg::MODE_MULTI)
      |=> (pix_last_o && !row_two_o) ##1 (pix_valid_o && row_two_o))
      else $error("row two did not follow row one");

   a_sum_clamp: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (q.st == tdi_pkg::ST_STREAM && sens_valid_i && q.mode == tdi_pkg::MODE_HISENS &&
       ({1'b0, row1_pix_i} + {1'b0, row2_pix_i}) > {1'b0, tdi_pkg::PIX_MAX})
      |=> (pix_o == tdi_pkg::PIX_MAX))
      else $error("sum wrapped instead of clamping");

endmodule // tdi_row_combiner

`default_nettype wire

// ### verif/sensor_model.sv
// Behavioural two-row sensor that streams a row pair after each readout request
`timescale 1ns/1ps
`default_nettype none

module sensor_model #(
   parameter int LEN = 8  // Pixels per row
) (
   input wire logic ref_clk_i,     // Pixel clock
   input wire logic line_req_i,    // Readout request
   input wire logic hdr_split_i,   // Row two exposed short
   output logic sens_valid_o,      // Pixel pair valid
   output logic sens_last_o,       // Last pair of the rows
   output logic [11:0] row1_o,     // Row one pixel
   output logic [11:0] row2_o      // Row two pixel
);
   // *****
   // Pixel source
   // *****
   logic [11:0] corner [6] = '{12'h000, 12'hfff, 12'heff, 12'hf00, 12'h7ff, 12'h800};

   // Mostly random, a quarter from the clamp and knee edges
   function automatic logic [11:0] pick();
      logic [31:0] r;
      r = $urandom;
      if (r[1:0] != 2'b00) return r[27:16];
      return corner[r[4:2] % 6];
   endfunction

   // Released lines toggle so stale data never looks like a pixel
   task automatic idle();
      sens_valid_o = 1'b0;
      sens_last_o = 1'b0;
      row1_o = ~row1_o;
      row2_o = ~row2_o;
      @(posedge ref_clk_i);
      #1;
   endtask

   // *****
   // Readout process, one step per cycle just after the edge
   // *****
   initial begin
      sens_valid_o = 1'b0;
      sens_last_o = 1'b0;
      row1_o = 12'h5a5;
      row2_o = 12'ha5a;
      @(posedge ref_clk_i);
      #1;
      forever begin
         if (line_req_i === 1'b1) begin
            repeat (1 + $urandom_range(3, 0)) idle();
            for (int i = 0; i < LEN; i++) begin
               // Gaps inside the row test spacing freedom
               if ($urandom_range(3, 0) == 0) idle();
               sens_valid_o = 1'b1;
               sens_last_o = (i == LEN - 1);
               row1_o = pick();
               // Short exposure gives a dimmer row two
               row2_o = hdr_split_i ? (pick() >> 1) : pick();
               @(posedge ref_clk_i);
               #1;
            end
            idle();
         end else begin
            idle();
         end
      end
   end
endmodule // sensor_model
`default_nettype wire

// ### verif/tdi_row_combiner_test.sv
// Self-checking bench of the two-row line combiner with random pixel traffic
`timescale 1ns/1ps
`default_nettype none

module tdi_row_combiner_test;
   // *****
   // Signals
   // *****
   localparam int LEN = 8;   // Pixels per row in this run
   localparam int PER = 80;  // Trigger spacing, cycles; longer than any line
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic trig = 1'b0;
   logic mode_load = 1'b0;
   logic [2:0] mode_sel = 3'h0;
   logic sens_valid, sens_last, line_req, hdr_split, pix_valid, pix_last, row_two, overrun;
   logic [11:0] row1, row2, pix;
   logic [2:0] mode;
   logic [23:0] integ;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;
   int pcnt = 40;            // Trigger phase; first trigger well after reset
   int ovr_cnt = 0;          // Overrun pulses seen
   int req_cnt = 0;          // Readout requests seen
   logic extra_trig = 1'b0;  // Forced pin edge inside a line
   logic [11:0] in1_q [$];   // Row one pixels seen by the design
   logic [11:0] in2_q [$];   // Row two pixels seen by the design
   logic [13:0] out_q [$];   // {row_two, last, pixel} leaving the design

   // *****
   // Design and sensor
   // *****
   tdi_row_combiner dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .external_line_trigger_i(trig),
      .mode_load_i(mode_load), .mode_sel_i(mode_sel), .sens_valid_i(sens_valid),
      .sens_last_i(sens_last), .row1_pix_i(row1), .row2_pix_i(row2), .line_req_o(line_req),
      .hdr_split_o(hdr_split), .mode_o(mode), .pix_o(pix), .pix_valid_o(pix_valid),
      .pix_last_o(pix_last), .row_two_o(row_two), .trig_overrun_o(overrun),
      .integ_cycles_o(integ));
   sensor_model #(.LEN(LEN)) sensor (.ref_clk_i(ref_clk_i), .line_req_i(line_req),
      .hdr_split_i(hdr_split), .sens_valid_o(sens_valid), .sens_last_o(sens_last),
      .row1_o(row1), .row2_o(row2));

   // Clock, 4 ns period
   initial begin
      forever #2 ref_clk_i = ~ref_clk_i;
   end

   // Trigger source at a fixed pitch, plus the cycle ceiling
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (!rst_i) begin
         pcnt <= (pcnt == PER - 1) ? 0 : pcnt + 1;
         trig <= #1 (pcnt < 4) || extra_trig;
      end
      // Ceiling last, so nothing runs after the verdict
      if (cycles == 5000) begin
         num_errors++;
         report_and_stop();
      end
   end

   // Monitors of both sides of the stream
   always @(posedge ref_clk_i) begin
      if (overrun === 1'b1) ovr_cnt++;
      if (line_req === 1'b1) req_cnt++;
      if (sens_valid === 1'b1) begin
         in1_q.push_back(row1);
         in2_q.push_back(row2);
      end
      if (pix_valid === 1'b1) out_q.push_back({row_two, pix_last, pix});
   end

   // *****
   // Helpers
   // *****
   // Expected output pixel for a mode and a row pair
   function automatic logic [11:0] exp_pix(int m, logic [11:0] a, logic [11:0] b, bit second);
      logic [13:0] s;
      s = {2'b00, a} + {2'b00, b};
      case (m)
         1: return (s > 14'h0fff) ? 12'hfff : s[11:0];
         2: return s[12:1];
         3: begin
            s = {2'b00, b} << tdi_pkg::HDR_SHIFT;
            if (a < tdi_pkg::HDR_KNEE) return a;
            return (s > 14'h0fff) ? 12'hfff : s[11:0];
         end
         4: return second ? b : a;
         default: return a;
      endcase
   endfunction

   task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Mode load while idle, then let mode and split settle
   task automatic load(logic [2:0] c);
      mode_sel = c;
      mode_load = 1'b1;
      @(posedge ref_clk_i);
      #1 mode_load = 1'b0;
      repeat (2) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // *****
   // Main sequence: one line per loop, every code first, then random codes
   // *****
   initial begin
      int m, cur, n, w;
      void'($urandom(32'hf8788050));
      cur = 0;
      repeat (5) @(posedge ref_clk_i);
      #1 rst_i = 1'b0;
      @(posedge ref_clk_i);
      #1;
      check("mode_o after reset", 24'(mode), 24'h0);
      for (int k = 0; k < 24; k++) begin
         m = (k < 8) ? k : $urandom_range(7, 0);
         load(3'(m));
         if (m <= 4) cur = m;  // Codes above four leave the mode alone
         check("mode_o", 24'(mode), 24'(cur));
         check("hdr_split_o", 24'(hdr_split), 24'(cur == 3));
         in1_q.delete();
         in2_q.delete();
         out_q.delete();
         w = 0;
         while (line_req !== 1'b1 && w < 200) begin
            @(posedge ref_clk_i);
            #1 w++;
         end
         // First period runs from reset, so it is not compared
         if (k > 0) check("integ_cycles_o", integ, 24'((cur inside {1, 2, 3}) ? 2 * PER : PER));
         // Last line only: a second pin edge mid-line must be dropped and flagged
         if (k == 23) begin
            repeat (2) @(posedge ref_clk_i);
            #1 extra_trig = 1'b1;
            repeat (3) @(posedge ref_clk_i);
            #1 extra_trig = 1'b0;
         end
         n = (cur == 4) ? 2 * LEN : LEN;
         w = 0;
         while (out_q.size() < n && w < 300) begin
            @(posedge ref_clk_i);
            #1 w++;
         end
         repeat (3) @(posedge ref_clk_i);
         #1;
         check("pixel count", 24'(out_q.size()), 24'(n));
         for (int i = 0; i < n && i < out_q.size() && i % LEN < in1_q.size(); i++) begin
            check("pixel", 24'(out_q[i]), 24'({i >= LEN, i % LEN == LEN - 1,
               exp_pix(cur, in1_q[i % LEN], in2_q[i % LEN], i >= LEN)}));
         end
      end
      check("trig_overrun_o pulses", 24'(ovr_cnt), 24'h1);
      check("line_req_o pulses", 24'(req_cnt), 24'd24);
      report_and_stop();
   end
endmodule // tdi_row_combiner_test
`default_nettype wire
